//--- acr_pkg.sv
// Purpose: constants and types for the converter readout timing block
// Assumes: 25 MHz ref_clk_i; shift clock sampled as a plain input
// Notes:   Behaviour list below
//
// Behaviour
// (RULE_01) host keeps sample rate within limits
// (RULE_02) host spaces convert edges by tCYC
// (RULE_03) conversion lasts 500 ns per channel minus 40; one channel keeps busy for 11 cycles (440 ns) here
// (RULE_04) host keeps interface quiet after convert
// (RULE_05) first data valid by busy fall
// (RULE_06) host shift clock period at least 10 ns
// (RULE_07) outputs enabled soon after select falls
// (RULE_08) outputs released soon after select rises
// (RULE_09) convert edge holds samples, starts conversion
// (RULE_10) busy high during conversion, echo clock low
// (RULE_11) power down ignores converts; twice resets
// (RULE_12) host shifts 6-bit range word in
// (RULE_13) host waits for busy before readout
package acr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS       = 40;
  localparam int CONV_CH_NS   = 500;
  localparam int CONV_OFS_NS  = 40;
  localparam int CONV1_NS     = CONV_CH_NS - CONV_OFS_NS;
  localparam int CONV2_NS     = 2 * CONV_CH_NS - CONV_OFS_NS;
  localparam int CONV1_CYC    = (CONV1_NS / CLK_NS) < 1 ? 1 : CONV1_NS / CLK_NS;
  localparam int CONV2_CYC    = (CONV2_NS / CLK_NS) < 1 ? 1 : CONV2_NS / CLK_NS;
  localparam int PUSH_LEAD    = 2;
  localparam int CNT_W        = 6;
  // ---------------------------------------------------------------
  // data layout
  // ---------------------------------------------------------------
  localparam int RES_W        = 18;
  localparam int CFG_W        = 6;
  localparam int WORD_W       = 24;
  localparam int BIT_W        = 5;
  localparam logic [CFG_W-1:0] CFG_RST = 6'h3F;
  localparam int FIFO_DEPTH   = 8;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_CONV = 2'b01,
    ACR_DOWN = 2'b10
  } acr_state_t;

  typedef struct packed {
    logic [RES_W-1:0] ch0;
    logic [RES_W-1:0] ch1;
  } acr_sample_t;

  typedef struct packed {
    logic ser0;
    logic ser1;
    logic ser_oe_n;
    logic echo;
  } acr_serial_t;
endpackage

//--- acr_fifo.sv
// Purpose: small valid/ready FIFO for conversion results
// Assumes: single clock
// Notes:   honest full and empty
`timescale 1ns/100ps
module acr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } acr_fifo_st_t;
  acr_fifo_st_t s_q, s_d;
  logic [W-1:0] mem_q [D];
  logic wr, rd;
  assign in_ready_o  = (s_q.cnt != (AW+1)'(D));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = mem_q[s_q.rp];
  assign wr = in_valid_i && in_ready_o;
  assign rd = out_valid_o && out_ready_i;
  always_comb begin
    s_d = s_q;
    if (wr) s_d.wp = s_q.wp + 1'b1;
    if (rd) s_d.rp = s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) s_q <= '0;
    else s_q <= s_d;
  end
  always_ff @(posedge ref_clk_i) begin
    if (wr) mem_q[s_q.wp] <= in_data_i;
  end
endmodule // acr_fifo

//--- acr_core.sv
// Purpose: convert sequencing, busy, power down and serial readout
// Assumes: pins sampled by ref_clk_i through two flip-flops
// Notes:   results are buffered in a FIFO ahead of readout
`timescale 1ns/100ps
module acr_core
  import acr_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 convert_start_i,
  input  wire logic                 power_down_in_i,
  input  wire logic                 select_n_i,
  input  wire logic                 shift_clock_in_i,
  input  wire logic                 config_data_in_i,
  input  wire logic                 two_ch_i,
  input  wire logic                 diff_mode_i,
  input  wire acr_pkg::acr_sample_t sample_i,
  output logic                      busy_o,
  output acr_pkg::acr_serial_t      serial_o,
  output logic [acr_pkg::CFG_W-1:0] range_cfg_o,
  output logic                      global_reset_o,
  output logic                      result_drop_o
);
  import acr_pkg::*;

  typedef struct packed {
    logic [4:0]       s1;
    logic [4:0]       s2;
    logic             cnv_p;
    logic             pd_p;
    logic             sck_p;
    acr_state_t       st;
    logic [CNT_W-1:0] cnt;
    logic             pd_pend;
    logic             pd_armed;
    logic             grst;
    acr_sample_t      held;
    logic [WORD_W-1:0] sh0;
    logic [WORD_W-1:0] sh1;
    logic [CFG_W-1:0] cfg_sh;
    logic [CFG_W-1:0] cfg;
    logic             busy;
    logic             echo;
    logic             oe_n;
    logic             push;
    logic             two;
    logic [CNT_W-1:0] bcnt;
  } acr_core_st_t;
  acr_core_st_t s_q, s_d;

  logic        f_ready, f_valid, pop;
  acr_sample_t f_data;

  // ---------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------
  acr_fifo #(.W($bits(acr_sample_t)), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (s_q.push),
    .in_ready_o  (f_ready),
    .in_data_i   (s_q.held),
    .out_valid_o (f_valid),
    .out_ready_i (pop),
    .out_data_o  (f_data)
  );

  logic convert_start, pd, sck, cs_n, config_data_in, cnv_rise, pd_rise, sck_rise;
  assign convert_start  = s_q.s2[0];
  assign pd   = s_q.s2[1];
  assign sck  = s_q.s2[2];
  assign cs_n = s_q.s2[3];
  assign config_data_in  = s_q.s2[4];
  assign cnv_rise = convert_start && !s_q.cnv_p;
  assign pd_rise  = pd && !s_q.pd_p;
  assign sck_rise = sck && !s_q.sck_p && !cs_n;
  // load a word while the bus is deselected
  assign pop = f_valid && cs_n && (s_q.st != ACR_CONV || s_q.cnt == '0); // RULE_05

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.s1 = {config_data_in_i, select_n_i, shift_clock_in_i,
              power_down_in_i, convert_start_i};
    s_d.s2 = s_q.s1;
    s_d.cnv_p = convert_start;
    s_d.pd_p  = pd;
    s_d.sck_p = sck;
    s_d.push = 1'b0;
    s_d.grst = 1'b0;
    s_d.oe_n = cs_n; // RULE_07 RULE_08
    if (pd_rise) begin
      s_d.pd_pend = 1'b1;
      if (s_q.pd_armed) s_d.grst = 1'b1; // RULE_11
      s_d.pd_armed = 1'b1;
    end
    unique case (s_q.st)
      ACR_IDLE: begin
        if (cnv_rise) begin // RULE_09
          s_d.held = sample_i;
          s_d.two  = two_ch_i;
          s_d.st   = ACR_CONV;
          s_d.busy = 1'b1; // RULE_10
          s_d.pd_armed = 1'b0;
          s_d.cnt  = two_ch_i ? CNT_W'(CONV2_CYC - 1) : CNT_W'(CONV1_CYC - 1); // RULE_03
        end else if (s_q.pd_pend || pd_rise) begin
          s_d.st = ACR_DOWN;
        end
      end
      ACR_CONV: begin
        if (s_q.cnt == '0) begin
          s_d.busy = 1'b0; // RULE_10
          s_d.echo = 1'b0; // RULE_10
          s_d.st   = (s_q.pd_pend || pd_rise) ? ACR_DOWN : ACR_IDLE; // RULE_11
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
          // push early so the word meets the shift register at busy fall
          if (s_q.cnt == CNT_W'(PUSH_LEAD)) s_d.push = 1'b1; // RULE_05
        end
      end
      ACR_DOWN: begin
        s_d.pd_pend = 1'b0;
        if (!pd && !s_q.pd_pend) s_d.st = ACR_IDLE; // RULE_11
      end
      default: s_d.st = ACR_IDLE;
    endcase
    if (s_q.grst) begin
      s_d.cfg = CFG_RST;
      s_d.st  = ACR_IDLE;
      s_d.busy = 1'b0;
      s_d.pd_armed = 1'b0;
    end
    if (pop) begin
      s_d.sh0 = {f_data.ch0, s_q.cfg};
      s_d.sh1 = {f_data.ch1, s_q.cfg};
    end else if (sck_rise) begin
      s_d.sh0 = {s_q.sh0[WORD_W-2:0], 1'b0};
      s_d.sh1 = {s_q.sh1[WORD_W-2:0], 1'b0};
      s_d.echo = !s_q.echo;
      s_d.cfg_sh = {s_q.cfg_sh[CFG_W-2:0], config_data_in};
    end
    if (s_q.busy && !s_d.busy) s_d.echo = 1'b0; // RULE_10
    if (cs_n && !s_q.oe_n) s_d.cfg = s_q.cfg_sh;
    s_d.bcnt = s_q.busy ? s_q.bcnt + 1'b1 : '0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.oe_n <= 1'b1;
      s_q.cfg <= CFG_RST;
      s_q.s1 <= 5'h08;
      s_q.s2 <= 5'h08;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o          = s_q.busy;
  assign serial_o.ser0   = s_q.sh0[WORD_W-1];
  assign serial_o.ser1   = s_q.sh1[WORD_W-1];
  assign serial_o.ser_oe_n = s_q.oe_n;
  assign serial_o.echo   = s_q.echo;
  assign range_cfg_o     = s_q.cfg;
  assign global_reset_o  = s_q.grst;
  assign result_drop_o   = s_q.push && !f_ready;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_conv_done;
    $fell(s_q.busy) && !$past(s_q.grst);
  endsequence
  property p_busy_start;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (s_q.st == ACR_IDLE && cnv_rise && !s_q.grst) |=> s_q.busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised"); // RULE_09
  property p_conv_len;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_conv_done |-> s_q.bcnt == (s_q.two ? CNT_W'(CONV2_CYC) : CNT_W'(CONV1_CYC));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // RULE_03
  property p_echo_low;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      $fell(s_q.busy) |-> !s_q.echo;
  endproperty
  a_echo_low: assert property (p_echo_low) else $error("echo not low"); // RULE_10
  property p_oe;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      $fell(cs_n) |=> !serial_o.ser_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("outputs not enabled"); // RULE_07
  property p_rel;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(cs_n) |=> serial_o.ser_oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("outputs not released"); // RULE_08
  property p_down;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (s_q.st == ACR_DOWN) |=> !$rose(s_q.busy);
  endproperty
  a_down: assert property (p_down) else $error("convert in power down"); // RULE_11
  property p_push;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_conv_done |-> $past(s_q.push, 2);
  endproperty
  a_push: assert property (p_push) else $error("result not stored"); // RULE_05
  property p_data_first;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (s_conv_done ##0 (cs_n && $past(cs_n) && !$past(f_valid, 2)))
        |-> (s_q.sh0[WORD_W-1 -: RES_W] == s_q.held.ch0)
            && (s_q.sh1[WORD_W-1 -: RES_W] == s_q.held.ch1);
  endproperty
  a_data_first: assert property (p_data_first) else $error("first word not ready"); // RULE_05
endmodule // acr_core

//--- acr_host.sv
// Purpose: host model on the convert and serial pins
// Assumes: pins change on ref_clk_i rising edges
// Notes:   shift clock idles low outside frames
`timescale 1ns/100ps
module acr_host
  import acr_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 busy_i,
  input  wire acr_pkg::acr_serial_t serial_i,
  output logic                      convert_o,
  output logic                      select_n_o,
  output logic                      sck_o,
  output logic                      sdi_o
);
  initial begin
    convert_o  = 1'b0;
    select_n_o = 1'b1;
    sck_o      = 1'b0;
    sdi_o      = 1'b0;
  end
  // ---------------------------------------------------------------
  // convert request
  // ---------------------------------------------------------------
  task automatic conv(input int gap);
    convert_o <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    convert_o <= 1'b0;
    repeat (gap) @(posedge ref_clk_i);
  endtask
  // ---------------------------------------------------------------
  // select level held without shifting
  // ---------------------------------------------------------------
  task automatic sel(input logic v);
    select_n_o <= v;
    repeat (12) @(posedge ref_clk_i);
  endtask
  // ---------------------------------------------------------------
  // readout frame
  // ---------------------------------------------------------------
  task automatic read(input logic [5:0] cfg, output logic [23:0] w0,
                      output logic [23:0] w1, output logic en, output logic dis);
    int t;
    t = 0;
    while (busy_i !== 1'b0 && t < 50) begin
      @(posedge ref_clk_i);
      t++;
    end
    select_n_o <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    en = serial_i.ser_oe_n;
    for (int i = 23; i >= 0; i--) begin
      sdi_o <= (i < 6) ? cfg[i] : 1'b0;
      repeat (4) @(posedge ref_clk_i);
      w0[i] = serial_i.ser0;
      w1[i] = serial_i.ser1;
      sck_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge ref_clk_i);
    select_n_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    dis = serial_i.ser_oe_n;
  endtask
endmodule // acr_host

//--- acr_core_tb.sv
// Purpose: self-checking bench for acr_core and acr_fifo
// Assumes: 25 MHz clock, host model on the pins
// Notes:   shift clock period 320 ns
`timescale 1ns/100ps
module acr_core_tb;
  import acr_pkg::*;
  logic             ref_clk_i, rst_n_i, convert_start, pd, sel_n, sck, config_data_in, two_ch, busy_o, grst, drop;
  logic             dm, en, dis;
  logic [23:0]      w0, w1;
  logic [CFG_W-1:0] cfg;
  acr_sample_t      smp;
  acr_serial_t      ser;
  int               fails = 0, check_count = 0, bcnt = 0, blen = 0, nconv = 0, n, ndrop = 0;
  acr_core DUT (.ref_clk_i, .rst_n_i, .convert_start_i(convert_start), .power_down_in_i(pd),
    .select_n_i(sel_n), .shift_clock_in_i(sck), .config_data_in_i(config_data_in), .two_ch_i(two_ch),
    .diff_mode_i(dm), .sample_i(smp), .busy_o, .serial_o(ser), .range_cfg_o(cfg),
    .global_reset_o(grst), .result_drop_o(drop));
  acr_host host (.ref_clk_i, .busy_i(busy_o), .serial_i(ser), .convert_o(convert_start),
    .select_n_o(sel_n), .sck_o(sck), .sdi_o(config_data_in));
  // ---------------------------------------------------------------
  // clock, busy width, compares
  // ---------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (drop === 1'b1) ndrop++;
    if (busy_o === 1'b1) bcnt++;
    else if (bcnt != 0) begin
      blen = bcnt;
      bcnt = 0;
      nconv++;
    end
  end
  task automatic chk_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t bit mismatch", $time);
    end
  endtask
  task automatic chk_word(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t word %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input int g, input int e);
    check_count++;
    if (g != e) begin
      fails++;
      $display("[ERR] %0t count %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_single();
    chk_word({18'h0, cfg}, {18'h0, CFG_RST});
    chk_bit(ser.ser_oe_n, 1'b1);
    smp <= '{ch0: 18'h2A5C3, ch1: 18'h15A3C};
    @(posedge ref_clk_i);
    host.conv(23);
    chk_cnt(blen, CONV1_CYC);
    chk_bit(ser.echo, 1'b0);
    host.read(6'h15, w0, w1, en, dis);
    chk_word(w0, {18'h2A5C3, CFG_RST});
    chk_word(w1, {18'h15A3C, CFG_RST});
    chk_bit(en, 1'b0);
    chk_bit(dis, 1'b1);
    chk_word({18'h0, cfg}, 24'h15);
  endtask
  task automatic t_dual();
    two_ch <= 1'b1;
    dm <= 1'b1;
    smp <= '{ch0: 18'h0F0F1, ch1: 18'h30C3A};
    @(posedge ref_clk_i);
    host.conv(36);
    chk_cnt(blen, CONV2_CYC);
    host.read(6'h2A, w0, w1, en, dis);
    chk_word(w0, {18'h0F0F1, 6'h15});
    chk_word(w1, {18'h30C3A, 6'h15});
    chk_bit(en, 1'b0);
    two_ch <= 1'b0;
    dm <= 1'b0;
  endtask
  task automatic t_ignore();
    n = nconv;
    host.conv(4);
    host.conv(23);
    chk_cnt(nconv - n, 1);
    chk_cnt(blen, CONV1_CYC);
    host.read(6'h2A, w0, w1, en, dis);
    chk_word(w0, {18'h0F0F1, 6'h2A});
  endtask
  task automatic t_fifo();
    host.conv(23);
    host.sel(1'b0);
    n = ndrop;
    for (int i = 1; i <= 9; i++) begin
      if (i == 9) chk_cnt(ndrop - n, 0);
      smp <= '{ch0: 18'(i) + 18'h00010, ch1: 18'(i) + 18'h00020};
      @(posedge ref_clk_i);
      host.conv(23);
    end
    chk_cnt(ndrop - n, 1);
    host.sel(1'b1);
    host.read(6'h2A, w0, w1, en, dis);
    chk_word(w0, {18'h00018, 6'h2A});
    chk_word(w1, {18'h00028, 6'h2A});
  endtask
  task automatic t_pd();
    n = nconv;
    pd <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    host.conv(23);
    chk_cnt(nconv - n, 0);
    pd <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    pd <= 1'b1;
    for (int t = 0; t < 10 && grst !== 1'b1; t++) @(posedge ref_clk_i);
    chk_bit(grst, 1'b1);
    @(posedge ref_clk_i);
    chk_word({18'h0, cfg}, {18'h0, CFG_RST});
    pd <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    pd      = 1'b0;
    two_ch  = 1'b0;
    smp     = '0;
    dm      = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_single();
    t_dual();
    t_ignore();
    t_fifo();
    t_pd();
    summarize();
  end
  initial begin
    repeat (6000) @(posedge ref_clk_i);
    fails++;
    summarize();
  end
endmodule // acr_core_tb
